// [pkg/oeir_defines.vh]
// Purpose: Constants for the OTG event interrupt register group
// Assumes: Byte-wide register port with 6-bit addresses
// Notes:   Included by rtl/oeir_regs.v
`ifndef OEIR_DEFINES_VH
`define OEIR_DEFINES_VH

// ************************************************************
// Register addresses
// ************************************************************
`define OEIR_ADDR_RISE_WR   6'h0d
`define OEIR_ADDR_RISE_SET  6'h0e
`define OEIR_ADDR_RISE_CLR  6'h0f
`define OEIR_ADDR_FALL_WR   6'h10
`define OEIR_ADDR_FALL_SET  6'h11
`define OEIR_ADDR_FALL_CLR  6'h12
`define OEIR_ADDR_STATUS    6'h13
`define OEIR_ADDR_LATCH     6'h14
`define OEIR_OFS_SET        6'h01
`define OEIR_OFS_CLR        6'h02

// ************************************************************
// Field layout and reset values
// ************************************************************
`define OEIR_SRC_W          5
`define OEIR_SRC_MSB        4
`define OEIR_BIT_ID_GROUND  4
`define OEIR_BIT_SESS_OVER  3
`define OEIR_BIT_SESS_OK    2
`define OEIR_BIT_BUS_PWR    1
`define OEIR_BIT_DETACH     0
`define OEIR_EN_RESET       5'h1f
`define OEIR_SRC_ZERO       5'h00
`define OEIR_PAD_ZERO       3'h0
`define OEIR_BYTE_ZERO      8'h00

`endif

// [rtl/oeir_regs.v]
// Purpose: Edge enables, live status and event latch of OTG event sources
// Assumes: Register port already decoded from the link; sources synchronous
// Notes:   Edge detection compares each source with its previous sample
`timescale 1ns/1ps
`include "oeir_defines.vh"

module oeir_regs (
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [5:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	input  wire       low_power,
	input  wire       id_ground_level,
	input  wire       session_over_level,
	input  wire       session_ok_signal,
	input  wire       bus_power_ok_signal,
	input  wire       downstream_detach_level,
	output wire       event_pulse,
	output reg  [4:0] event_sources
);

	// ************************************************************
	// Enable registers
	// ************************************************************
	reg  [4:0] rise_en_reg;
	reg  [4:0] rise_en_next;
	reg  [4:0] fall_en_reg;
	reg  [4:0] fall_en_next;
	reg  [4:0] level_reg;
	reg  [4:0] latch_reg;
	reg  [4:0] latch_next;
	reg        low_power_reg;
	reg  [4:0] event_sources_next;
	wire [4:0] level_now;
	wire [4:0] rise_hit;
	wire [4:0] fall_hit;
	wire [4:0] change;
	wire       latch_read;
	wire       low_power_entry;

	// Write, set or clear selected by address; only the low five bits exist
	function [4:0] wsc;
		input [4:0] cur;
		input [4:0] data;
		input [5:0] addr;
		input [5:0] base;
		begin
			if (addr == base)
				wsc = data;
			else if (addr == base + `OEIR_OFS_SET)
				wsc = cur | data;
			else if (addr == base + `OEIR_OFS_CLR)
				wsc = cur & ~data;
			else
				wsc = cur;
		end
	endfunction

	always @* begin
		rise_en_next = rise_en_reg;
		fall_en_next = fall_en_reg;
		if (reg_wr) begin
			rise_en_next = wsc(rise_en_reg, reg_wdata[`OEIR_SRC_MSB:0], reg_addr,
				`OEIR_ADDR_RISE_WR);
			fall_en_next = wsc(fall_en_reg, reg_wdata[`OEIR_SRC_MSB:0], reg_addr,
				`OEIR_ADDR_FALL_WR);
		end
	end

	// ************************************************************
	// Source levels and edge detection
	// ************************************************************
	assign level_now[`OEIR_BIT_ID_GROUND] = id_ground_level;
	assign level_now[`OEIR_BIT_SESS_OVER] = session_over_level;
	assign level_now[`OEIR_BIT_SESS_OK]   = session_ok_signal;
	assign level_now[`OEIR_BIT_BUS_PWR]   = bus_power_ok_signal;
	assign level_now[`OEIR_BIT_DETACH]    = downstream_detach_level;

	// Previous sample resets to zero, so a source high out of reset counts as a rise
	assign rise_hit = level_now & ~level_reg & rise_en_reg;
	assign fall_hit = ~level_now & level_reg & fall_en_reg;
	assign change   = rise_hit | fall_hit;
	assign event_pulse = |event_sources;

	assign latch_read      = reg_rd && (reg_addr == `OEIR_ADDR_LATCH);
	assign low_power_entry = low_power && !low_power_reg;

	// ************************************************************
	// Event latch
	// ************************************************************
	always @* begin
		latch_next = latch_reg;
		if (latch_read || low_power_entry)
			latch_next = `OEIR_SRC_ZERO;
		// New events win over the clear so none is lost
		latch_next = latch_next | change;
		event_sources_next = change;
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rise_en_reg   <= `OEIR_EN_RESET;
			fall_en_reg   <= `OEIR_EN_RESET;
			level_reg     <= `OEIR_SRC_ZERO;
			latch_reg     <= `OEIR_SRC_ZERO;
			low_power_reg <= 1'b0;
			event_sources <= `OEIR_SRC_ZERO;
		end else begin
			rise_en_reg   <= rise_en_next;
			fall_en_reg   <= fall_en_next;
			level_reg     <= level_now;
			latch_reg     <= latch_next;
			low_power_reg <= low_power;
			event_sources <= event_sources_next;
		end
	end

	// ************************************************************
	// Read data, registered one cycle after the read strobe
	// ************************************************************
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `OEIR_BYTE_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				`OEIR_ADDR_RISE_WR, `OEIR_ADDR_RISE_SET, `OEIR_ADDR_RISE_CLR:
					reg_rdata <= {`OEIR_PAD_ZERO, rise_en_reg};
				`OEIR_ADDR_FALL_WR, `OEIR_ADDR_FALL_SET, `OEIR_ADDR_FALL_CLR:
					reg_rdata <= {`OEIR_PAD_ZERO, fall_en_reg};
				`OEIR_ADDR_STATUS:
					reg_rdata <= {`OEIR_PAD_ZERO, level_now};
				`OEIR_ADDR_LATCH:
					reg_rdata <= {`OEIR_PAD_ZERO, latch_reg};
				default:
					reg_rdata <= `OEIR_BYTE_ZERO;
			endcase
		end
	end

endmodule // oeir_regs

// [tb/oeir_chk_asserts.sv]
// Purpose: Port checks of oeir_regs
// Assumes: Bound by name to the top module's ports
// Notes:   Enables are not visible here
`timescale 1ns/1ps
module oeir_chk (
	input wire       mclk,
	input wire       reset_n,
	input wire       reg_rd,
	input wire [5:0] reg_addr,
	input wire [7:0] reg_rdata,
	input wire       low_power,
	input wire       id_ground_level,
	input wire       session_over_level,
	input wire       session_ok_signal,
	input wire       bus_power_ok_signal,
	input wire       downstream_detach_level,
	input wire       event_pulse,
	input wire [4:0] event_sources
);
	wire [4:0] s = {id_ground_level, session_over_level, session_ok_signal,
		bus_power_ok_signal, downstream_detach_level};
	wire       r14 = reg_rd && reg_addr == 6'h14;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_or; event_pulse == |event_sources; endproperty
	a_or: assert property (p_or) else $error("pulse");
	property p_cause; event_sources != 5'h00 |-> (event_sources & ~($past(s) ^ $past(s, 2))) == 5'h00; endproperty
	a_cause: assert property (p_cause) else $error("cause");
	property p_stat; reg_rd && reg_addr == 6'h13 |=> reg_rdata == {3'h0, $past(s)}; endproperty
	a_stat: assert property (p_stat) else $error("status");
	property p_resv; reg_rd |=> reg_rdata[7:5] == 3'h0; endproperty
	a_resv: assert property (p_resv) else $error("reserved");
	property p_unmap; reg_rd && (reg_addr < 6'h0d || reg_addr > 6'h14) |=> reg_rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_clr; r14 ##1 !event_pulse ##1 (r14 && !event_pulse) |=> reg_rdata[4:0] == 5'h00; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_lp; $rose(low_power) ##1 (r14 && !event_pulse) |=> reg_rdata[4:0] == 5'h00; endproperty
	a_lp: assert property (p_lp) else $error("low power");
endmodule // oeir_chk
bind oeir_regs oeir_chk u_chk (.*);

// [tb/oeir_link.sv]
// Purpose: Link side of the register port
// Assumes: One access at a time
// Notes:   Latch reads are optional for the link
`timescale 1ns/1ps
module oeir_link (
	input  wire       mclk,
	output reg        reg_wr,
	output reg        reg_rd,
	output reg  [5:0] reg_addr,
	output reg  [7:0] reg_wdata,
	input  wire [7:0] reg_rdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 16'h0000;
	// Released address and data lines show the inverse so a stale value cannot pass; strobes go low
	task acc(input w, input [5:0] a, input [7:0] d, output [7:0] q);
		begin
			@(posedge mclk) #1;
			{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
			@(posedge mclk) #1;
			{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
			q = reg_rdata;
		end
	endtask
endmodule // oeir_link

// [tb/oeir_regs_tb_top.sv]
// Purpose: Register and event bench
// Assumes: 50 ns clock
// Notes:   Latch read twice to see the clear
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; $display("mismatch %0t %h", $time, a); end end
module oeir_regs_tb_top;
	reg        mclk, reset_n, low_power;
	reg  [4:0] src;
	reg  [7:0] q;
	wire       reg_wr, reg_rd, event_pulse;
	wire [5:0] reg_addr;
	wire [7:0] reg_wdata, reg_rdata;
	wire [4:0] event_sources;
	int        err_count = 0, num_checks = 0;
	oeir_link link (.*);
	oeir_regs uut (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .low_power(low_power),
		.id_ground_level(src[4]), .session_over_level(src[3]), .session_ok_signal(src[2]),
		.bus_power_ok_signal(src[1]), .downstream_detach_level(src[0]),
		.event_pulse(event_pulse), .event_sources(event_sources));
	task wrap_up;
		begin
			$display("errors %0d checks %0d", err_count, num_checks);
			if (err_count == 0 && num_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task rd(input [5:0] a, input [7:0] e);
		begin
			link.acc(1'b0, a, 8'h00, q);
			`CHK(q, e)
		end
	endtask
	task wait_ev(input [4:0] e);
		int n;
		begin
			for (n = 0; n < 8 && event_pulse !== 1'b1; n++) @(posedge mclk) #1;
			if (event_pulse !== 1'b1) begin
				err_count++;
				wrap_up;
			end
			`CHK(event_sources, e)
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		{reset_n, low_power, src} = 7'h00;
		repeat (4) @(posedge mclk);
		#1 reset_n = 1'b1;
		rd(6'h0d, 8'h1f);
		rd(6'h10, 8'h1f);
		rd(6'h14, 8'h00);
		link.acc(1'b1, 6'h0d, 8'hff, q);
		link.acc(1'b1, 6'h0f, 8'h05, q);
		link.acc(1'b1, 6'h0e, 8'h01, q);
		rd(6'h0e, 8'h1b);
		link.acc(1'b1, 6'h10, 8'h00, q);
		link.acc(1'b1, 6'h11, 8'h15, q);
		link.acc(1'b1, 6'h12, 8'h04, q);
		rd(6'h12, 8'h11);
		link.acc(1'b1, 6'h13, 8'hff, q);
		rd(6'h20, 8'h00);
		src = 5'h15;
		wait_ev(5'h11);
		rd(6'h13, 8'h15);
		rd(6'h14, 8'h11);
		rd(6'h14, 8'h00);
		src = 5'h00;
		wait_ev(5'h11);
		rd(6'h14, 8'h11);
		src = 5'h0a;
		wait_ev(5'h0a);
		low_power = 1'b1;
		rd(6'h14, 8'h00);
		wrap_up;
	end
endmodule // oeir_regs_tb_top
